// *** hw/qac_pkg.sv ***
// Shared constants for the four-channel parallel serial capture block.
// Assumes a 20 MHz system clock; timing counts derive from it here.
package qac_pkg;
    // Channel and word layout
    localparam int NUM_CH = 4;
    localparam int SAMPLE_BITS = 24;
    localparam int MEM_WORD_BITS = 32;
    localparam int IN_WORD_BITS = 8;
    localparam int DATA_LSB = 0;
    localparam int GATHER_SHIFT = 4;
    localparam int PAD_BITS = MEM_WORD_BITS - SAMPLE_BITS;
    localparam int CH_IDX_W = $clog2(NUM_CH);
    localparam int BIT_CNT_W = $clog2(SAMPLE_BITS);
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(SAMPLE_BITS - 1);
    localparam logic [CH_IDX_W-1:0] LAST_CH = CH_IDX_W'(NUM_CH - 1);

    // Timing, in nanoseconds as given, then in system clock cycles
    localparam int MCLK_PERIOD_NS = 50;
    localparam int SCLK_HALF_NS = 50;
    localparam int CONVST_NS = 100;
    localparam int CONV_WAIT_NS = 10000;
    // Half period of the serial clock rounds down (longest time)
    localparam int SCLK_HALF_CYC_RAW = SCLK_HALF_NS / MCLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_CYC_RAW < 1) ? 1 : SCLK_HALF_CYC_RAW;
    // Start pulse and conversion wait round up (least times)
    localparam int CONVST_CYC = (CONVST_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CONV_WAIT_CYC = (CONV_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int TMR_W = 8;

    // Reset values
    localparam logic [SAMPLE_BITS-1:0] SAMPLE_RST = 24'h000000;
    localparam logic [PAD_BITS-1:0] PAD_ZERO = 8'h00;

    // Sequencer states
    typedef enum logic [2:0] {
        QAC_IDLE,
        QAC_START,
        QAC_CONV,
        QAC_BURST,
        QAC_WAIT_DATA,
        QAC_STORE
    } qac_state_t;
endpackage

// *** hw/qac_lane.sv ***
// One channel's serial-to-parallel sample register.
// Clocked by the falling edge of the returned serial clock.
`timescale 1ns/1ps
module qac_lane
    import qac_pkg::*;
#(
    parameter int WIDTH = SAMPLE_BITS
) (
    // Link clock and reset
    input wire logic clk_n_i,
    input wire logic rst_n_i,
    // Bit stream in
    input wire logic bit_i,
    // Assembled word
    output logic [WIDTH-1:0] word_o,
    output logic [WIDTH-1:0] word_next_o
);
    logic [WIDTH-1:0] word_reg;

    // MSB first: each bit pushes the older ones up
    assign word_next_o = {word_reg[WIDTH-2:0], bit_i};
    assign word_o = word_reg;

    always_ff @(negedge clk_n_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_reg <= '0;
        end else begin
            word_reg <= word_next_o;
        end
    end
endmodule

// *** hw/qac_capture.sv ***
// Four-channel parallel serial capture: drives shared clock, start and command line,
// captures four converter lines on the returned clock, stores 32-bit words in two buffers.
// Assumes the returned clock idles between bursts and one memory write is taken per cycle.
`timescale 1ns/1ps
module qac_capture
    import qac_pkg::*;
#(
    parameter int BUF_WORDS = 256,
    parameter int SCLK_HALF = SCLK_HALF_CYC,
    parameter int CONV_CYC = CONV_WAIT_CYC
) (
    // System clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    // Control
    input wire logic run_i,
    input wire logic [SAMPLE_BITS-1:0] cfg_word_i,
    input wire logic cfg_load_i,
    // Link side
    input wire logic returned_clock_input_i,
    input wire logic [IN_WORD_BITS-1:0] parallel_input_word_i,
    output logic sclk_o,
    output logic convst_o,
    output logic shared_cmd_o,
    // Shared memory write port
    output logic mem_we_o,
    output logic [$clog2(BUF_WORDS):0] mem_addr_o,
    output logic [MEM_WORD_BITS-1:0] mem_wdata_o,
    // Host event
    output logic buf_full_o,
    output logic full_buf_id_o,
    output logic busy_o
);
    localparam int IDX_W = $clog2(BUF_WORDS);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(BUF_WORDS - 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SCLK_HALF - 1);
    localparam int CNT_W = $clog2(CONV_CYC + CONVST_CYC + 1);
    localparam logic [CNT_W-1:0] CONVST_LAST = CNT_W'(CONVST_CYC - 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

    // ---------------- Link domain: returned clock ----------------
    logic [IN_WORD_BITS-1:0] bit_gather_register;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic frame_tgl_reg;
    logic [SAMPLE_BITS-1:0] lane_next [NUM_CH];
    logic [SAMPLE_BITS-1:0] hold_reg [NUM_CH];
    logic frame_done;

    assign bit_gather_register = IN_WORD_BITS'(parallel_input_word_i[DATA_LSB +: NUM_CH]) << GATHER_SHIFT;
    assign frame_done = (bit_cnt_reg == LAST_BIT);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_lane
            qac_lane #(
                .WIDTH(SAMPLE_BITS)
            ) u_lane (
                .clk_n_i(returned_clock_input_i),
                .rst_n_i(rst_n_i),
                .bit_i(bit_gather_register[GATHER_SHIFT + gi]),
                .word_o(),
                .word_next_o(lane_next[gi])
            );
        end
    endgenerate

    always_ff @(negedge returned_clock_input_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_reg <= '0;
            frame_tgl_reg <= 1'b0;
        end else if (frame_done) begin
            bit_cnt_reg <= '0;
            frame_tgl_reg <= ~frame_tgl_reg;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
    end

    // Hold assembled samples for the system domain
    always_ff @(negedge returned_clock_input_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                hold_reg[c] <= SAMPLE_RST;
            end
        end else if (frame_done) begin
            for (int c = 0; c < NUM_CH; c++) begin
                hold_reg[c] <= lane_next[c];
            end
        end
    end

    // ---------------- System domain ----------------
    logic tgl_s1_reg;
    logic tgl_s2_reg;
    logic tgl_s3_reg;
    logic frame_evt;
    logic cap_pend_reg;
    logic [SAMPLE_BITS-1:0] snap_reg [NUM_CH];

    // Toggle crossing for frame completion
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
        end else if (en_i) begin
            tgl_s1_reg <= frame_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end
    assign frame_evt = tgl_s2_reg ^ tgl_s3_reg;

    // Free-running timer
    logic [TMR_W-1:0] tmr_cnt_reg;
    logic tmr_phase_reg;
    logic tmr_wrap;
    logic sync_en_reg;
    logic [BIT_CNT_W-1:0] sclk_cnt_reg;
    logic sclk_fall;
    logic sclk_rise_ok;

    assign tmr_wrap = (tmr_cnt_reg == TMR_LAST);
    assign sclk_fall = tmr_wrap & tmr_phase_reg & sync_en_reg;
    assign sclk_rise_ok = tmr_wrap & ~tmr_phase_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_cnt_reg <= '0;
            tmr_phase_reg <= 1'b0;
        end else if (en_i) begin
            tmr_cnt_reg <= tmr_wrap ? '0 : tmr_cnt_reg + 1'b1;
            tmr_phase_reg <= tmr_wrap ? ~tmr_phase_reg : tmr_phase_reg;
        end
    end

    // Sequencer
    qac_state_t state_reg;
    qac_state_t state_next;
    logic [CNT_W-1:0] wait_cnt_reg;
    logic [CH_IDX_W-1:0] ch_reg;
    logic [IDX_W-1:0] wr_idx_reg;
    logic buf_sel_reg;
    logic [SAMPLE_BITS-1:0] cmd_sh_reg;
    logic cfg_pend_reg;
    logic [SAMPLE_BITS-1:0] cfg_hold_reg;
    logic burst_start;
    logic burst_enter;
    logic burst_end;
    logic store_go;
    logic buf_wrap;

    assign burst_start = (state_reg == QAC_BURST) & ~sync_en_reg & sclk_rise_ok & (sclk_cnt_reg == '0);
    assign burst_end = sclk_fall & (sclk_cnt_reg == LAST_BIT);
    assign store_go = (state_reg == QAC_STORE);
    assign buf_wrap = store_go & (wr_idx_reg == LAST_IDX);
    assign burst_enter = (state_reg == QAC_CONV) & (state_next == QAC_BURST);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            QAC_IDLE: begin
                if (run_i) begin
                    state_next = QAC_START;
                end
            end
            QAC_START: begin
                if (wait_cnt_reg == CONVST_LAST) begin
                    state_next = QAC_CONV;
                end
            end
            QAC_CONV: begin
                if (wait_cnt_reg == CONV_LAST) begin
                    state_next = QAC_BURST;
                end
            end
            QAC_BURST: begin
                if (burst_end) begin
                    state_next = QAC_WAIT_DATA;
                end
            end
            QAC_WAIT_DATA: begin
                if (cap_pend_reg) begin
                    state_next = QAC_STORE;
                end
            end
            QAC_STORE: begin
                if (ch_reg == LAST_CH) begin
                    state_next = run_i ? QAC_START : QAC_IDLE;
                end
            end
            default: begin
                state_next = QAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= QAC_IDLE;
            wait_cnt_reg <= '0;
        end else if (en_i) begin
            state_reg <= state_next;
            wait_cnt_reg <= (state_next != state_reg) ? '0 : wait_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_en_reg <= 1'b0;
            sclk_cnt_reg <= '0;
        end else if (en_i) begin
            if (burst_start) begin
                sync_en_reg <= 1'b1;
            end else if (burst_end) begin
                sync_en_reg <= 1'b0;
            end
            if (burst_end) begin
                sclk_cnt_reg <= '0;
            end else if (sclk_fall) begin
                sclk_cnt_reg <= sclk_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_o <= 1'b0;
            convst_o <= 1'b0;
        end else if (en_i) begin
            sclk_o <= (sync_en_reg | burst_start) & (tmr_wrap ? ~tmr_phase_reg : tmr_phase_reg) & ~burst_end;
            convst_o <= (state_next == QAC_START);
        end
    end

    // one command line to all converters, MSB first
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_pend_reg <= 1'b0;
            cfg_hold_reg <= SAMPLE_RST;
            cmd_sh_reg <= SAMPLE_RST;
        end else if (en_i) begin
            if (cfg_load_i) begin
                cfg_hold_reg <= cfg_word_i;
            end
            if (cfg_load_i) begin
                cfg_pend_reg <= 1'b1;
            end else if (burst_enter) begin
                cfg_pend_reg <= 1'b0;
            end
            // Loaded a cycle ahead so the MSB is set up before the first rise
            if (burst_enter) begin
                cmd_sh_reg <= cfg_pend_reg ? cfg_hold_reg : SAMPLE_RST;
            end else if (sclk_fall) begin
                cmd_sh_reg <= {cmd_sh_reg[SAMPLE_BITS-2:0], 1'b0};
            end
        end
    end
    assign shared_cmd_o = cmd_sh_reg[SAMPLE_BITS-1];

    // Snapshot of captured samples; new frame wins over clear
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_pend_reg <= 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
                snap_reg[c] <= SAMPLE_RST;
            end
        end else if (en_i) begin
            if (frame_evt) begin
                cap_pend_reg <= 1'b1;
                for (int c = 0; c < NUM_CH; c++) begin
                    snap_reg[c] <= hold_reg[c];
                end
            end else if (state_reg == QAC_WAIT_DATA) begin
                cap_pend_reg <= 1'b0;
            end
        end
    end

    // widen to 32 bits, one word per channel
    // one-cycle pulse, next buffer at once
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ch_reg <= '0;
            wr_idx_reg <= '0;
            buf_sel_reg <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= '0;
            buf_full_o <= 1'b0;
            full_buf_id_o <= 1'b0;
            busy_o <= 1'b0;
        end else if (en_i) begin
            mem_we_o <= store_go;
            buf_full_o <= buf_wrap;
            busy_o <= (state_next != QAC_IDLE);
            if (store_go) begin
                mem_addr_o <= {buf_sel_reg, wr_idx_reg};
                mem_wdata_o <= {PAD_ZERO, snap_reg[ch_reg]};
                ch_reg <= (ch_reg == LAST_CH) ? '0 : ch_reg + 1'b1;
                wr_idx_reg <= buf_wrap ? '0 : wr_idx_reg + 1'b1;
                if (buf_wrap) begin
                    buf_sel_reg <= ~buf_sel_reg;
                    full_buf_id_o <= buf_sel_reg;
                end
            end
        end
    end
endmodule

// *** sim/qac_capture_checker.sv ***
// Port timing checks of the capture block.
// Assumes a bind to qac_capture; system clock domain only.
`timescale 1ns/1ps
module qac_capture_checker
    import qac_pkg::*;
#(
    parameter int BUF_WORDS = 256
) (
    // Clock, reset, control
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic run_i,
    // Design outputs
    input wire logic sclk_o,
    input wire logic convst_o,
    input wire logic shared_cmd_o,
    input wire logic mem_we_o,
    input wire logic [$clog2(BUF_WORDS):0] mem_addr_o,
    input wire logic [MEM_WORD_BITS-1:0] mem_wdata_o,
    input wire logic buf_full_o,
    input wire logic full_buf_id_o,
    input wire logic busy_o
);
    localparam int AW = $clog2(BUF_WORDS) + 1;
    logic [5:0] edge_cnt_reg;
    logic sclk_q_reg;
    logic [AW-1:0] last_addr_reg;
    logic seen_reg;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Serial clock rises since the last start pulse, last address written
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edge_cnt_reg <= 6'h00;
            sclk_q_reg <= 1'b0;
            last_addr_reg <= '0;
            seen_reg <= 1'b0;
        end else begin
            sclk_q_reg <= sclk_o;
            if (convst_o) begin
                edge_cnt_reg <= 6'h00;
            end else if (sclk_o && !sclk_q_reg) begin
                edge_cnt_reg <= edge_cnt_reg + 6'h01;
            end
            if (mem_we_o) begin
                last_addr_reg <= mem_addr_o;
                seen_reg <= 1'b1;
            end
        end
    end
    sequence convst_pulse;
        convst_o ##1 convst_o ##1 !convst_o;
    endsequence
    sequence write_group;
        mem_we_o [*4] ##1 !mem_we_o;
    endsequence
    a_start_on_run: assert property (!busy_o && run_i && en_i |=> convst_o && busy_o)
        else $error("no start after run");
    a_convst_width: assert property ($rose(convst_o) |-> convst_pulse)
        else $error("start pulse width wrong");
    a_idle_quiet: assert property (!busy_o |-> !sclk_o && !shared_cmd_o)
        else $error("serial lines active while idle");
    a_burst_count: assert property ($rose(mem_we_o) |-> edge_cnt_reg == 6'h18)
        else $error("burst not 24 clocks");
    a_write_group: assert property ($rose(mem_we_o) |-> write_group)
        else $error("not four writes per conversion");
    a_pad_zero: assert property (mem_we_o |-> mem_wdata_o[31:24] == 8'h00)
        else $error("upper byte not zero");
    a_addr_step: assert property (mem_we_o && seen_reg |-> mem_addr_o == last_addr_reg + 1'b1)
        else $error("address did not step");
    a_first_addr: assert property (mem_we_o && !seen_reg |-> mem_addr_o == '0)
        else $error("first write not at zero");
    a_full_index: assert property (buf_full_o |-> mem_we_o && full_buf_id_o == mem_addr_o[AW-1]
        && mem_addr_o[AW-2:0] == (AW-1)'(BUF_WORDS - 1)) else $error("full at wrong place");
    a_full_needed: assert property (mem_we_o && mem_addr_o[AW-2:0] == (AW-1)'(BUF_WORDS - 1) |-> buf_full_o)
        else $error("full missing");
    a_full_single: assert property (buf_full_o |=> !buf_full_o)
        else $error("full longer than a cycle");
endmodule

bind qac_capture qac_capture_checker #(.BUF_WORDS(BUF_WORDS)) qac_capture_checker_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .en_i(en_i), .run_i(run_i), .sclk_o(sclk_o),
    .convst_o(convst_o), .shared_cmd_o(shared_cmd_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .buf_full_o(buf_full_o), .full_buf_id_o(full_buf_id_o), .busy_o(busy_o));

// *** sim/qac_adc_model.sv ***
// Four synchronized 24-bit serial converters.
// Assumes the serial clock stands still between bursts.
`timescale 1ns/1ps
module qac_adc_model (
    // From capture block
    input wire logic sclk_i,
    input wire logic convst_i,
    input wire logic cmd_i,
    input wire logic [95:0] samp_i,
    // Back to capture block
    output logic ret_clk_o,
    output logic [7:0] dout_o,
    // Observation
    output logic [23:0] cmd_word_o,
    output int edges_o
);
    logic [95:0] shift_reg;
    int falls;
    initial begin
        ret_clk_o = 1'b0;
        dout_o = 8'h00;
        cmd_word_o = 24'h000000;
        edges_o = 0;
        falls = 0;
        shift_reg = '0;
    end
    always @(posedge convst_i) begin
        shift_reg = samp_i;
        edges_o = 0;
        falls = 0;
    end
    always @(sclk_i) ret_clk_o <= #7 sclk_i;
    always @(posedge sclk_i) begin
        cmd_word_o = {cmd_word_o[22:0], cmd_i};
        edges_o = edges_o + 1;
    end
    always @(posedge ret_clk_o) begin
        for (int c = 0; c < 4; c++) begin
            dout_o[c] = shift_reg[c*24+23];
            shift_reg[c*24 +: 24] = shift_reg[c*24 +: 24] << 1;
        end
        dout_o[7:4] = ~dout_o[7:4];
    end
    always @(negedge ret_clk_o) begin
        falls = falls + 1;
        if (falls == 24) begin
            #20 dout_o[3:0] = ~dout_o[3:0];
        end
    end
endmodule

// *** sim/quad_adc_parallel_spi_capture_test.sv ***
// Testbench of the capture block against the converter model.
// Assumes short counts: 8-word buffers, 4-cycle conversion wait.
`timescale 1ns/1ps
module quad_adc_parallel_spi_capture_test;
    import qac_pkg::*;
    localparam int BUFW = 8;
    localparam int AW = $clog2(BUFW) + 1;
    localparam logic [23:0] CFG = 24'h3C5A96;
    typedef struct {int n; int ch; logic [AW-1:0] addr; logic [31:0] data; logic full;} qac_row_t;
    logic mclk_i, rst_n_i, en_i, run_i, cfg_load_i, ret_clk, sclk_o, convst_o, shared_cmd_o;
    logic mem_we_o, buf_full_o, full_buf_id_o, busy_o;
    logic [23:0] cfg_word_i, cmd_word;
    logic [7:0] in_word;
    logic [AW-1:0] mem_addr_o, wr_addr [32];
    logic [31:0] mem_wdata_o, wr_data [32];
    logic wr_full [32], wr_id [32];
    logic [95:0] samp_w;
    int edges, conv_cnt = 0, wcount = 0, failures = 0, tests_run = 0;
    qac_row_t rows [16];
    function automatic logic [23:0] sample(int n, int c);
        return 24'hA53C96 ^ {4'(n), 4'(c), 16'(16'h0F31 * (c + 1))};
    endfunction
    assign samp_w = {sample(conv_cnt, 3), sample(conv_cnt, 2), sample(conv_cnt, 1), sample(conv_cnt, 0)};
    qac_capture #(.BUF_WORDS(BUFW), .CONV_CYC(4)) qac_capture_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .en_i(en_i), .run_i(run_i), .cfg_word_i(cfg_word_i), .cfg_load_i(cfg_load_i),
        .returned_clock_input_i(ret_clk), .parallel_input_word_i(in_word), .sclk_o(sclk_o),
        .convst_o(convst_o), .shared_cmd_o(shared_cmd_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .buf_full_o(buf_full_o), .full_buf_id_o(full_buf_id_o), .busy_o(busy_o));
    qac_adc_model qac_adc_model_inst (.sclk_i(sclk_o), .convst_i(convst_o), .cmd_i(shared_cmd_o),
        .samp_i(samp_w), .ret_clk_o(ret_clk), .dout_o(in_word), .cmd_word_o(cmd_word), .edges_o(edges));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        #200000;
        failures++;
        $display("BAD t=%0t watchdog expired", $time);
        stop_test();
    end
    always @(negedge convst_o) conv_cnt++;
    always @(negedge mclk_i) begin
        if (mem_we_o === 1'b1 && wcount < 32) begin
            if (wcount % 4 == 0) begin
                check(32'(edges), 32'h18);
                check(32'(cmd_word), (wcount == 0) ? 32'(CFG) : 32'h0);
            end
            wr_addr[wcount] = mem_addr_o;
            wr_data[wcount] = mem_wdata_o;
            wr_full[wcount] = buf_full_o;
            wr_id[wcount] = full_buf_id_o;
            wcount++;
        end
    end
    initial begin
        {rst_n_i, en_i, run_i, cfg_load_i} = 4'h0;
        cfg_word_i = 24'h000000;
        for (int i = 0; i < 16; i++) begin
            rows[i] = '{i / 4, i % 4, AW'(i), {8'h00, sample(i / 4, i % 4)}, (i % BUFW) == BUFW - 1};
        end
        repeat (2) @(negedge mclk_i);
        rst_n_i = 1'b1;
        @(negedge mclk_i);
        check({sclk_o, convst_o, mem_we_o, busy_o}, 32'h0);
        en_i = 1'b1;
        cfg_word_i = CFG;
        cfg_load_i = 1'b1;
        @(negedge mclk_i);
        {cfg_load_i, en_i, run_i} = 3'h1;
        repeat (5) @(negedge mclk_i);
        check({convst_o, busy_o}, 32'h0);
        $display("test reset and freeze done");
        en_i = 1'b1;
        for (int k = 0; k < 4000 && conv_cnt < 4; k++) @(negedge mclk_i);
        run_i = 1'b0;
        for (int k = 0; k < 4000 && busy_o !== 1'b0; k++) @(negedge mclk_i);
        @(negedge mclk_i);
        check(32'(wcount), 32'h10);
        for (int i = 0; i < 16; i++) begin
            check(32'(wr_addr[i]), 32'(rows[i].addr));
            check(wr_data[i], rows[i].data);
            check(32'(wr_full[i]), 32'(rows[i].full));
            if (rows[i].full) check(32'(wr_id[i]), 32'(i / BUFW));
        end
        $display("test four conversions done");
        run_i = 1'b1;
        for (int k = 0; k < 4000 && conv_cnt < 5; k++) @(negedge mclk_i);
        rst_n_i = 1'b0;
        run_i = 1'b0;
        @(negedge mclk_i);
        check({sclk_o, convst_o, mem_we_o, busy_o}, 32'h0);
        rst_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        check({busy_o, shared_cmd_o}, 32'h0);
        $display("test reset mid run done");
        stop_test();
    end
endmodule
